// [rtl/soft_serial_pkg.sv]
package soft_serial_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] RATE_OFF   = 8'h04;
  localparam logic [7:0] DELAY_OFF  = 8'h08;
  localparam logic [7:0] TXDATA_OFF = 8'h0C;
  localparam logic [7:0] RXDATA_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  localparam logic [7:0] PINS_OFF   = 8'h18;

  // control register fields
  localparam int CTRL_INVERT_BIT = 0;
  localparam int CTRL_MARKER_BIT = 1;
  localparam int CTRL_TXIDLE_BIT = 2;
  // command word (written to status offset): bit0 timed rx, bit1 hunting rx
  localparam int CMD_TIMED_BIT   = 0;
  localparam int CMD_HUNT_BIT    = 1;

  // status fields
  localparam int ST_RX_BUSY_BIT  = 0;
  localparam int ST_RX_DONE_BIT  = 1;
  localparam int ST_TX_BUSY_BIT  = 2;
  localparam int ST_IRQ_BLK_BIT  = 3;
  localparam int ST_RX_INV_BIT   = 4;

  // reset values
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0004;
  localparam logic [31:0] RATE_RESET  = 32'h0000_0000;
  localparam logic [31:0] DELAY_RESET = 32'h0000_0000;

  // counted-loop timing, in cycles
  localparam int LOOP_CYCLES    = 4;
  localparam int BIT_OVERHEAD   = 11;
  localparam int FIRST_OVERHEAD = 16;
  localparam int MARKER_CYCLES  = 3;

  // line-rate divider limits, clock cycles per bit
  localparam int RATE_DIV_MIN = 19;
  localparam int RATE_DIV_MAX = 262159;

  // frame shape
  localparam int DATA_BITS = 8;
  localparam int RATE_W    = 19;

  typedef enum logic [5:0] {
    RX_IDLE  = 6'b000001,
    RX_IDLEV = 6'b000010,
    RX_HUNT  = 6'b000100,
    RX_FIRST = 6'b001000,
    RX_BITS  = 6'b010000,
    RX_TAIL  = 6'b100000
  } rx_state_e;

  typedef struct packed {
    logic       start;
    logic [7:0] data;
    logic       invert;
  } tx_req_s;

  typedef struct packed {
    logic       busy;
    logic       line;
  } tx_stat_s;

endpackage

// [rtl/serial_tx.sv]
`timescale 1ns/1ps
module serial_tx
  import soft_serial_pkg::*;
#(
  parameter int RW = RATE_W
) (
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // request and rate
  input  wire tx_req_s       req,
  input  wire logic [RW-1:0] bit_cycles,
  // line and state
  output tx_stat_s           stat
);

  logic [RW-1:0] cnt;
  logic [9:0]    shifter;
  logic [3:0]    left;

  // one frame: start at non-idle, 8 data lsb first, stop at idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt       <= '0;
      shifter   <= 10'h3FF;
      left      <= 4'h0;
      stat.busy <= 1'b0;
      stat.line <= 1'b1;
    end else if (!stat.busy) begin
      stat.line <= ~req.invert;
      if (req.start) begin
        shifter   <= {1'b1, req.data, 1'b0} ^ {10{req.invert}};
        left      <= 4'hA;
        cnt       <= '0;
        stat.busy <= 1'b1;
      end
    end else if (cnt == '0) begin
      if (left == 4'h0) begin
        stat.busy <= 1'b0;
      end else begin
        stat.line <= shifter[0];
        shifter   <= {1'b1, shifter[9:1]};
        left      <= left - 4'h1;
        cnt       <= bit_cycles - RW'(1);
      end
    end else begin
      cnt <= cnt - RW'(1);
    end
  end

endmodule

// [rtl/soft_serial.sv]
`timescale 1ns/1ps
module soft_serial
  import soft_serial_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int RW     = RATE_W
) (
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial line
  input  wire logic [PORT_W-1:0] port_in,
  output logic             tx_line,
  output logic             sample_marker_pin,
  // system interrupt gate
  output logic             irq_block
);

  // software state
  logic [31:0]       ctrl;
  logic [RW-1:0]     line_rate;
  logic [15:0]       bit_period_loops;
  logic [15:0]       first_sample_loops;
  logic [PORT_W-1:0] pin_select_mask;
  logic [7:0]        tx_byte;
  logic              tx_go;
  logic              go_timed;
  logic              go_hunt;

  // bus address phase capture
  logic       dp_write;
  logic       dp_read;
  logic [7:0] dp_addr;

  // receiver state
  rx_state_e     rx_state;
  logic [RW+1:0] rx_cnt;
  logic [7:0]    rx_shift;
  logic [3:0]    rx_bits;
  logic [7:0]    rx_data;
  logic          rx_done;
  logic          rx_inv;
  logic          rx_mode_hunt;
  logic          rx_pin;
  logic          rx_blk;

  tx_req_s  tx_req;
  tx_stat_s tx_stat;

  // one-hot mask selects one pin of the port; several bits or none reads low
  function automatic logic pick_pin(input logic [PORT_W-1:0] p,
                                    input logic [PORT_W-1:0] m);
    pick_pin = ($countones(m) == 1) && |(p & m);
  endfunction

  // counted-loop cycles: overhead plus four per loop, none added for zero loops
  function automatic logic [RW+1:0] loops_to_cycles(input int base,
                                                     input logic [15:0] loops);
    loops_to_cycles = (RW+2)'(base) + (RW+2)'({loops, 2'b00});
  endfunction

  assign rx_pin    = pick_pin(port_in, pin_select_mask);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase: register the request when the bus is ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_write <= hsel && htrans[1] && hwrite;
      dp_read  <= hsel && htrans[1] && !hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  // write data phase; command strobes last one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl               <= CTRL_RESET;
      line_rate          <= RW'(RATE_RESET);
      bit_period_loops   <= DELAY_RESET[15:0];
      first_sample_loops <= DELAY_RESET[15:0];
      pin_select_mask    <= PORT_W'(1);
      tx_byte            <= 8'h00;
      tx_go              <= 1'b0;
      go_timed           <= 1'b0;
      go_hunt            <= 1'b0;
    end else begin
      tx_go    <= 1'b0;
      go_timed <= 1'b0;
      go_hunt  <= 1'b0;
      if (dp_write) begin
        case (dp_addr)
          CTRL_OFF:   ctrl <= {29'h0, hwdata[2:0]};
          RATE_OFF:   line_rate <= hwdata[RW-1:0];
          DELAY_OFF: begin
            bit_period_loops   <= hwdata[15:0];
            first_sample_loops <= hwdata[31:16];
          end
          TXDATA_OFF: begin
            tx_byte <= hwdata[7:0];
            tx_go   <= 1'b1;
          end
          STATUS_OFF: begin
            go_timed <= hwdata[CMD_TIMED_BIT];
            go_hunt  <= hwdata[CMD_HUNT_BIT];
          end
          PINS_OFF:   pin_select_mask <= hwdata[PORT_W-1:0];
          default:    ;
        endcase
      end
    end
  end

  // read data; unmapped offsets read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        CTRL_OFF:   hrdata <= ctrl;
        RATE_OFF:   hrdata <= 32'(line_rate);
        DELAY_OFF:  hrdata <= {first_sample_loops, bit_period_loops};
        TXDATA_OFF: hrdata <= {24'h0, tx_byte};
        RXDATA_OFF: hrdata <= {24'h0, rx_data};
        STATUS_OFF: hrdata <= {27'h0, rx_inv, irq_block, tx_stat.busy,
                               rx_done, rx_bits != 4'h0 || rx_state != RX_IDLE};
        PINS_OFF:   hrdata <= 32'(pin_select_mask);
        default:    hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // receive sequencer for both modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state     <= RX_IDLE;
      rx_cnt       <= '0;
      rx_shift     <= 8'h00;
      rx_bits      <= 4'h0;
      rx_inv       <= 1'b0;
      rx_mode_hunt <= 1'b0;
      rx_blk       <= 1'b0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_blk <= 1'b0;
          if (go_timed) begin
            rx_mode_hunt <= 1'b0;
            rx_inv       <= ctrl[CTRL_INVERT_BIT];
            rx_blk       <= 1'b1;
            rx_cnt       <= loops_to_cycles(FIRST_OVERHEAD, first_sample_loops)
                            + (ctrl[CTRL_MARKER_BIT] ? (RW+2)'(MARKER_CYCLES)
                                                     : '0);
            rx_state     <= RX_FIRST;
          end else if (go_hunt) begin
            rx_mode_hunt <= 1'b1;
            rx_state     <= RX_IDLEV;
          end
        end
        RX_IDLEV: begin
          rx_inv   <= ~rx_pin;
          rx_state <= RX_HUNT;
        end
        RX_HUNT: begin
          // no timeout here: a silent line keeps the receiver waiting
          if (rx_pin == rx_inv) begin
            rx_blk   <= 1'b1;
            rx_cnt   <= (RW+2)'(line_rate >> 1);
            rx_state <= RX_FIRST;
          end
        end
        RX_FIRST: begin
          if (rx_cnt <= (RW+2)'(1)) begin
            rx_bits  <= 4'h0;
            rx_cnt   <= rx_mode_hunt ? (RW+2)'(line_rate)
                        : loops_to_cycles(BIT_OVERHEAD, bit_period_loops);
            rx_state <= RX_BITS;
          end else begin
            rx_cnt <= rx_cnt - (RW+2)'(1);
          end
        end
        RX_BITS: begin
          if (rx_cnt <= (RW+2)'(1)) begin
            rx_shift <= {rx_pin ^ rx_inv, rx_shift[7:1]};
            rx_bits  <= rx_bits + 4'h1;
            rx_cnt   <= rx_mode_hunt ? (RW+2)'(line_rate)
                        : loops_to_cycles(BIT_OVERHEAD, bit_period_loops);
            if (rx_bits == 4'(DATA_BITS - 1)) begin
              rx_state <= RX_TAIL;
            end
          end else begin
            rx_cnt <= rx_cnt - (RW+2)'(1);
          end
        end
        RX_TAIL: begin
          // stop bit level is ignored, so no framing error can arise
          rx_bits  <= 4'h0;
          rx_blk   <= 1'b0;
          rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // result byte and done flag; a new capture wins over a read clearing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data <= 8'h00;
      rx_done <= 1'b0;
    end else if (rx_state == RX_TAIL) begin
      rx_data <= rx_shift;
      rx_done <= 1'b1;
    end else if (dp_read && dp_addr == RXDATA_OFF) begin
      rx_done <= 1'b0;
    end
  end

  // diagnostic marker toggles in timed mode only, three cycles before the first-sample delay ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_marker_pin <= 1'b0;
    end else if (rx_state == RX_FIRST && ctrl[CTRL_MARKER_BIT] && !rx_mode_hunt
                 && rx_cnt == (RW+2)'(MARKER_CYCLES + 1)) begin
      sample_marker_pin <= ~sample_marker_pin;
    end
  end

  // transmit polarity follows the idle level software sets
  assign tx_req.start  = tx_go;
  assign tx_req.data   = tx_byte;
  assign tx_req.invert = ~ctrl[CTRL_TXIDLE_BIT];

  serial_tx #(
    .RW (RW)
  ) u_tx (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .req        (tx_req),
    .bit_cycles (line_rate),
    .stat       (tx_stat)
  );

  assign tx_line   = tx_stat.line;
  assign irq_block = rx_blk | tx_stat.busy;

endmodule

// [verification/soft_serial_asserts.sv]
`timescale 1ns/1ps
module soft_serial_asserts
  import soft_serial_pkg::*;
#(
  parameter int PORT_W = 8
) (
  // bus side
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // line side
  input wire logic [PORT_W-1:0] port_in,
  input wire logic              tx_line,
  input wire logic              sample_marker_pin,
  input wire logic              irq_block
);
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  a_q;
  logic [31:0] ctrl;
  logic [31:0] rate;
  logic [19:0] age;
  logic [19:0] blk;

  // shadow the bus writes so line levels can be judged from the ports alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      a_q  <= 8'h0;
      ctrl <= CTRL_RESET;
      rate <= RATE_RESET;
    end else begin
      wr_q <= hsel && htrans[1] && hready && hwrite;
      rd_q <= hsel && htrans[1] && hready && !hwrite;
      a_q  <= haddr[7:0];
      if (wr_q && a_q == CTRL_OFF) ctrl <= hwdata;
      if (wr_q && a_q == RATE_OFF) rate <= hwdata;
    end
  end

  // age of the control value, and length of the blocked spell
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age <= 20'h0;
      blk <= 20'h0;
    end else begin
      age <= (wr_q && a_q == CTRL_OFF) ? 20'h0 : age + {19'h0, age != 20'hFFFFF};
      blk <= irq_block ? blk + 20'h1 : 20'h0;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ready_always:
    assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay:
    assert property (!hresp) else $error("hresp not okay");
  a_unmapped_zero:
    assert property (rd_q && a_q > 8'h18 |-> hrdata == 32'h0) else $error("unmapped read");
  a_idle_level:
    assert property (!irq_block && !$past(irq_block) && age > 20'h4
      |-> $past(tx_line) == ctrl[CTRL_TXIDLE_BIT]) else $error("tx idle level");
  a_stop_idle:
    assert property ($fell(irq_block) && age > 20'h4 |-> tx_line == ctrl[CTRL_TXIDLE_BIT])
      else $error("stop not idle");
  a_block_min:
    assert property ($rose(irq_block) |-> irq_block [*8]) else $error("block too short");
  a_block_max:
    assert property (blk <= rate[19:0] * 20'hB + 20'h40) else $error("block too long");
  a_marker_gated:
    assert property ($changed(sample_marker_pin) |-> ctrl[CTRL_MARKER_BIT])
      else $error("marker while off");

  // main scenarios reached
  c_frame_end: cover property ($fell(irq_block));
  c_marker: cover property ($changed(sample_marker_pin));
  c_unmapped: cover property (rd_q && a_q > 8'h18);
endmodule

bind soft_serial soft_serial_asserts #(.PORT_W(PORT_W)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .port_in(port_in), .tx_line(tx_line),
  .sample_marker_pin(sample_marker_pin), .irq_block(irq_block)
);

// [verification/serial_far_end.sv]
`timescale 1ns/1ps
module serial_far_end (
  // clock
  input  wire logic hclk,
  // lines
  input  wire logic tx_line,
  output logic      rx_pin
);
  // far device idles high until told otherwise
  initial rx_pin = 1'h1;

  // park the line at its idle level
  task automatic rest(input logic inv);
    rx_pin <= ~inv;
  endtask

  // start, eight bits lsb first, stop level chosen so a bad stop can be forced
  task automatic send(input logic [7:0] b, input int per, input logic inv, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rx_pin <= f[i] ^ inv;
      repeat (per) @(posedge hclk);
    end
    rest(inv);
  endtask

  // sample each bit mid-window after the start edge
  task automatic recv(input int per, input logic inv, output logic [7:0] b, output logic stp);
    wait (tx_line === inv);
    repeat (per / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (per) @(posedge hclk);
      b[i] = tx_line ^ inv;
    end
    repeat (per) @(posedge hclk);
    stp = tx_line ^ inv;
  endtask
endmodule

// [verification/bit_banged_serial_8n1_test.sv]
`timescale 1ns/1ps
module bit_banged_serial_8n1_test;
  import soft_serial_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        rx_pin;
  logic        tx_line;
  logic        marker;
  logic        irq_block;
  int          n_errors;
  int          n_checks;

  // spare port bits carry the inverse of the pin, so a wrong mask shows up
  soft_serial #(.PORT_W(8)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .port_in({~{7{rx_pin}}, rx_pin}),
    .tx_line(tx_line), .sample_marker_pin(marker), .irq_block(irq_block)
  );
  serial_far_end i_far (.hclk(hclk), .tx_line(tx_line), .rx_pin(rx_pin));

  // bus clock
  initial begin
    hclk = 1'h0;
    forever #2 hclk = ~hclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // address phase held until hready is sampled high
  task automatic aph(input logic [7:0] a, input logic w);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aph(a, 1'h1);
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    aph(a, 1'h0);
    do @(posedge hclk); while (hready !== 1'h1);
    d = hrdata;
  endtask

  // poll one status bit; the watchdog bounds the wait
  task automatic wait_st(input int b, input logic v);
    logic [31:0] s;
    rd(STATUS_OFF, s);
    while (s[b] !== v) rd(STATUS_OFF, s);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    rd(CTRL_OFF, d);
    chk("ctrl reset", CTRL_RESET, d);
    rd(8'h1C, d);
    chk("unmapped", 32'h0, d);
    wr(RATE_OFF, 32'h28);
    $display("regs test done");
  endtask

  // two bytes back to back; a write while busy must not disturb the frame
  task automatic t_tx(input logic inv);
    logic [7:0] b;
    logic       s;
    wr(CTRL_OFF, {29'h0, ~inv, 2'h0});
    repeat (4) @(posedge hclk);
    for (int i = 0; i < 2; i++) begin
      fork
        i_far.recv(40, inv, b, s);
        begin
          wr(TXDATA_OFF, i ? 32'h3C : 32'hA5);
          wr(TXDATA_OFF, 32'hFF);
          chk("irq_block", 32'h1, {31'h0, irq_block});
        end
      join
      chk("tx byte", i ? 32'h3C : 32'hA5, {24'h0, b});
      chk("tx stop", 32'h1, {31'h0, s});
      wait_st(ST_TX_BUSY_BIT, 1'h0);
    end
    $display("tx test done");
  endtask

  // idle level picks polarity, no timeout while waiting, stop level ignored
  task automatic t_hunt(input logic inv, input logic bad);
    logic [31:0] d;
    i_far.rest(inv);
    repeat (4) @(posedge hclk);
    wr(STATUS_OFF, 32'h2);
    repeat (600) @(posedge hclk);
    rd(STATUS_OFF, d);
    chk("hunting", {27'h0, inv, 4'h1}, d & 32'h1F);
    i_far.send(8'h96, 40, inv, ~bad);
    wait_st(ST_RX_DONE_BIT, 1'h1);
    rd(RXDATA_OFF, d);
    chk("hunt byte", 32'h96, d);
    rd(STATUS_OFF, d);
    chk("done cleared", 32'h0, d & 32'h2);
    $display("hunt test done");
  endtask

  // counted-loop receive on an inverted line, strobe enabled, start already present
  task automatic t_timed;
    logic [31:0] d;
    logic        m;
    wr(CTRL_OFF, 32'h7);
    wr(DELAY_OFF, 32'h7);
    i_far.rest(1'h1);
    m = marker;
    repeat (4) @(posedge hclk);
    fork
      i_far.send(8'h5A, 39, 1'h1, 1'h1);
      begin
        @(posedge hclk);
        wr(STATUS_OFF, 32'h1);
      end
    join
    wait_st(ST_RX_DONE_BIT, 1'h1);
    rd(RXDATA_OFF, d);
    chk("timed byte", 32'h5A, d);
    chk("marker", {31'h0, ~m}, {31'h0, marker});
    $display("timed test done");
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // tests need well under 10000 cycles
  initial begin
    repeat (30000) @(posedge hclk);
    n_errors++;
    stop_test;
  end

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_errors = 0;
    n_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    t_regs;
    t_tx(1'h0);
    t_tx(1'h1);
    t_hunt(1'h0, 1'h0);
    t_hunt(1'h1, 1'h1);
    t_timed;
    stop_test;
  end
endmodule
